//--- src/srw_pkg.sv
// Purpose: Shared constants and types for the supervisor reset and watchdog block
// Assumes: 200 MHz clock
// Notes: Register offsets are word addresses on the plain register port
package srw_pkg;

    localparam int unsigned SRW_CLK_HZ = 200_000_000;

    // Power-up reset delays in microseconds
    localparam int unsigned SRW_PURST0_US = 50_000;
    localparam int unsigned SRW_PURST1_US = 200_000;
    localparam int unsigned SRW_PURST2_US = 400_000;
    localparam int unsigned SRW_PURST3_US = 800_000;
    // Watchdog periods in microseconds
    localparam int unsigned SRW_WD0_US = 1_400_000;
    localparam int unsigned SRW_WD1_US = 200_000;
    localparam int unsigned SRW_WD2_US = 25_000;

    localparam int unsigned SRW_CYC_PER_US = SRW_CLK_HZ / 1_000_000;
    localparam longint unsigned SRW_PURST0_CYC = longint'(SRW_PURST0_US) * SRW_CYC_PER_US;
    localparam longint unsigned SRW_PURST1_CYC = longint'(SRW_PURST1_US) * SRW_CYC_PER_US;
    localparam longint unsigned SRW_PURST2_CYC = longint'(SRW_PURST2_US) * SRW_CYC_PER_US;
    localparam longint unsigned SRW_PURST3_CYC = longint'(SRW_PURST3_US) * SRW_CYC_PER_US;
    localparam longint unsigned SRW_WD0_CYC = longint'(SRW_WD0_US) * SRW_CYC_PER_US;
    localparam longint unsigned SRW_WD1_CYC = longint'(SRW_WD1_US) * SRW_CYC_PER_US;
    localparam longint unsigned SRW_WD2_CYC = longint'(SRW_WD2_US) * SRW_CYC_PER_US;

    localparam int SRW_CNT_W = 29;

    // Register map (word addresses)
    localparam logic [3:0] SRW_ADDR_CTRL = 4'h0;
    localparam logic [3:0] SRW_ADDR_STAT = 4'h1;
    localparam logic [3:0] SRW_ADDR_IRQ_STAT = 4'h2;
    localparam logic [3:0] SRW_ADDR_IRQ_MASK = 4'h3;

    // Control register fields
    localparam int SRW_CTRL_PUP0 = 0;
    localparam int SRW_CTRL_WD_LO = 5;
    localparam int SRW_CTRL_WD_HI = 6;
    localparam int SRW_CTRL_PUP1 = 7;
    localparam logic [1:0] SRW_PUP_RST = 2'h1;
    localparam logic [1:0] SRW_WD_RST = 2'h3;
    localparam logic [1:0] SRW_WD_OFF = 2'h3;

    // Event bits for the interrupt status and mask
    localparam int SRW_EV_RESET = 0;
    localparam int SRW_EV_EARLY_SUPPLY_LOW_N = 1;
    localparam int SRW_EV_V2 = 2;
    localparam int SRW_EV_V3 = 3;
    localparam int SRW_EV_WDOG = 4;
    localparam int SRW_EV_W = 5;
    localparam logic [SRW_EV_W-1:0] SRW_MASK_RST = 5'h00;
    localparam logic [SRW_EV_W-1:0] SRW_PREV_RST = 5'h0E;

    typedef struct packed {
        logic main_ok;
        logic second_ok;
        logic third_ok;
        logic manual_reset_n;
    } srw_sense_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } srw_req_t;

endpackage

//--- src/srw_sync.sv
// Purpose: Two-flop synchroniser for a bundle of levels
// Assumes: Inputs are slow levels
// Notes: Reset value is given by parameter
`timescale 1ns/1ps
module srw_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

//--- src/srw_top.sv
// Purpose: Supervisor reset sequencing, supply fail flags, watchdog and write protect
// Assumes: Comparator results arrive as logic levels, high while the supply is above trip
// Notes: Register port replaces the serial control register of the part
`timescale 1ns/1ps
module srw_top
    import srw_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire srw_sense_t sense,
    input wire logic write_protect,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire srw_req_t req,
    output logic [7:0] rdata_q,
    output logic mem_wr_en_q,
    output logic reset_n_oe_q,
    output logic reset_q,
    output logic early_supply_low_n_q,
    output logic second_supply_fail_n_oe_q,
    output logic third_supply_fail_n_oe_q,
    output logic watchdog_alarm_n_oe_q,
    output logic irq_q
);
    logic rst_meta_q;
    logic rst_n_q;
    srw_sense_t sense_s;
    logic [1:0] bus_s;
    logic scl_q;
    logic sda_q;
    logic start_seen_q;
    logic low_seen_q;
    logic high_seen_q;
    logic restart;
    logic wr_ok;
    logic [1:0] pup_q;
    logic [1:0] wd_sel_q;
    logic [SRW_CNT_W-1:0] rst_cnt_q;
    logic [SRW_CNT_W-1:0] rst_len;
    logic sys_rst_q;
    logic [SRW_CNT_W-1:0] wd_cnt_q;
    logic [SRW_CNT_W-1:0] wd_len;
    logic alarm_q;
    logic [SRW_EV_W-1:0] ev;
    logic [SRW_EV_W-1:0] ev_stat_q;
    logic [SRW_EV_W-1:0] ev_mask_q;
    logic [SRW_EV_W-1:0] prev_q;
    logic [SRW_EV_W-1:0] cur;

    // Reset release through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Supplies start as failing, manual reset as released
    srw_sync #(.W(4), .RST_VAL(4'h1)) u_sense_sync (
        .clk(clk),
        .rst_n(rst_n_q),
        .d(sense),
        .q(sense_s)
    );

    srw_sync #(.W(2), .RST_VAL(2'h3)) u_bus_sync (
        .clk(clk),
        .rst_n(rst_n_q),
        .d({scl_in, sda_in}),
        .q(bus_s)
    );

    // Bus condition tracker; delayed copies for edge detection
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= bus_s[1];
            sda_q <= bus_s[0];
        end
    end

    // Start, then a low and a high clock phase, then stop
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            start_seen_q <= 1'b0;
            low_seen_q <= 1'b0;
            high_seen_q <= 1'b0;
        end else if (scl_q && bus_s[1] && sda_q && !bus_s[0]) begin
            start_seen_q <= 1'b1;
            low_seen_q <= 1'b0;
            high_seen_q <= 1'b0;
        end else if (restart) begin
            start_seen_q <= 1'b0;
            low_seen_q <= 1'b0;
            high_seen_q <= 1'b0;
        end else if (start_seen_q && !bus_s[1]) begin
            low_seen_q <= 1'b1;
        end else if (low_seen_q && bus_s[1]) begin
            high_seen_q <= 1'b1;
        end
    end

    // Stop after a full start/low/high; any longer transfer passes through it too
    assign restart = high_seen_q && scl_q && bus_s[1] && !sda_q && bus_s[0];

    assign wr_ok = req.wr && !write_protect;

    // Control register: delay and watchdog selects
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pup_q <= SRW_PUP_RST;
            wd_sel_q <= SRW_WD_RST;
        end else if (wr_ok && req.addr == SRW_ADDR_CTRL) begin
            pup_q <= {req.wdata[SRW_CTRL_PUP1], req.wdata[SRW_CTRL_PUP0]};
            wd_sel_q <= req.wdata[SRW_CTRL_WD_HI:SRW_CTRL_WD_LO];
        end
    end

    // Memory write strobe gated by write protect
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mem_wr_en_q <= 1'b0;
        end else begin
            mem_wr_en_q <= wr_ok;
        end
    end

    always_comb begin
        case (pup_q)
            2'h0: rst_len = SRW_CNT_W'(SRW_PURST0_CYC);
            2'h1: rst_len = SRW_CNT_W'(SRW_PURST1_CYC);
            2'h2: rst_len = SRW_CNT_W'(SRW_PURST2_CYC);
            default: rst_len = SRW_CNT_W'(SRW_PURST3_CYC);
        endcase
    end

    // Reset delay: reloads while main supply low or manual reset held
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rst_cnt_q <= '0;
            sys_rst_q <= 1'b1;
        end else if (!sense_s.main_ok || !sense_s.manual_reset_n) begin
            rst_cnt_q <= '0;
            sys_rst_q <= 1'b1;
        end else if (sys_rst_q) begin
            if (rst_cnt_q >= rst_len - SRW_CNT_W'(1)) begin
                sys_rst_q <= 1'b0;
            end else begin
                rst_cnt_q <= rst_cnt_q + SRW_CNT_W'(1);
            end
        end
    end

    // Both reset flavours come from the same condition
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reset_q <= 1'b1;
            reset_n_oe_q <= 1'b1;
        end else begin
            reset_q <= sys_rst_q;
            reset_n_oe_q <= sys_rst_q;
        end
    end

    // Undelayed supply flags
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            early_supply_low_n_q <= 1'b0;
            second_supply_fail_n_oe_q <= 1'b1;
            third_supply_fail_n_oe_q <= 1'b1;
        end else begin
            early_supply_low_n_q <= sense_s.main_ok;
            second_supply_fail_n_oe_q <= !sense_s.second_ok;
            third_supply_fail_n_oe_q <= !sense_s.third_ok;
        end
    end

    always_comb begin
        case (wd_sel_q)
            2'h0: wd_len = SRW_CNT_W'(SRW_WD0_CYC);
            2'h1: wd_len = SRW_CNT_W'(SRW_WD1_CYC);
            2'h2: wd_len = SRW_CNT_W'(SRW_WD2_CYC);
            default: wd_len = '0;
        endcase
    end

    // Watchdog; the alarm stays until the next restart or until the watchdog is switched off
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wd_cnt_q <= '0;
            alarm_q <= 1'b0;
        end else if (restart || wd_sel_q == SRW_WD_OFF) begin
            wd_cnt_q <= '0;
            alarm_q <= 1'b0;
        end else if (!alarm_q) begin
            if (wd_cnt_q >= wd_len - SRW_CNT_W'(1)) begin
                alarm_q <= 1'b1;
            end else begin
                wd_cnt_q <= wd_cnt_q + SRW_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            watchdog_alarm_n_oe_q <= 1'b0;
        end else begin
            watchdog_alarm_n_oe_q <= alarm_q;
        end
    end

    // Events are rising edges of the fault conditions
    assign cur = {alarm_q, !sense_s.third_ok, !sense_s.second_ok, !sense_s.main_ok, sys_rst_q};
    assign ev = cur & ~prev_q;

    // History matches the synchroniser reset value, so power-up logs no false supply events
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            prev_q <= SRW_PREV_RST;
        end else begin
            prev_q <= cur;
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ev_stat_q <= '0;
        end else if (wr_ok && req.addr == SRW_ADDR_IRQ_STAT) begin
            ev_stat_q <= (ev_stat_q & ~req.wdata[SRW_EV_W-1:0]) | ev;
        end else begin
            ev_stat_q <= ev_stat_q | ev;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ev_mask_q <= SRW_MASK_RST;
        end else if (wr_ok && req.addr == SRW_ADDR_IRQ_MASK) begin
            ev_mask_q <= req.wdata[SRW_EV_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(ev_stat_q & ev_mask_q);
        end
    end

    // Read data valid the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 8'h00;
        end else if (req.rd) begin
            if (req.addr == SRW_ADDR_CTRL) begin
                rdata_q <= {pup_q[1], wd_sel_q, 4'h0, pup_q[0]};
            end else if (req.addr == SRW_ADDR_STAT) begin
                rdata_q <= {3'h0, cur};
            end else if (req.addr == SRW_ADDR_IRQ_STAT) begin
                rdata_q <= {3'h0, ev_stat_q};
            end else if (req.addr == SRW_ADDR_IRQ_MASK) begin
                rdata_q <= {3'h0, ev_mask_q};
            end else begin
                rdata_q <= 8'h00;
            end
        end else begin
            rdata_q <= 8'h00;
        end
    end
endmodule

//--- verif/srw_checker.sv
// Purpose: Port assertions for srw_top
// Assumes: Reset delay far longer than any run, so reset output stays active
// Notes: Gated a few cycles after release while the sync pipe still shows reset values
`timescale 1ns/1ps
module srw_checker
    import srw_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire srw_sense_t sense,
    input wire logic write_protect,
    input wire srw_req_t req,
    input wire logic mem_wr_en_q,
    input wire logic reset_n_oe_q,
    input wire logic reset_q,
    input wire logic early_supply_low_n_q,
    input wire logic second_supply_fail_n_oe_q,
    input wire logic third_supply_fail_n_oe_q
);
    logic [3:0] up_q;
    logic up;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) up_q <= 4'h0;
        else if (up_q != 4'hF) up_q <= up_q + 4'h1;
    end
    assign up = up_q > 4'h7;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wp_blocks_a: assert property (req.wr && write_protect |=> !mem_wr_en_q)
        else $error("write passed while protected");
    wr_pulse_a: assert property (up && req.wr && !write_protect |=> mem_wr_en_q)
        else $error("write not passed");
    third_low_a: assert property ((up && !sense.third_ok) [*5] |-> third_supply_fail_n_oe_q)
        else $error("third fail not shown");
    third_clear_a: assert property ((up && sense.third_ok) [*5] |-> !third_supply_fail_n_oe_q)
        else $error("third fail not released");
    second_flag_a: assert property ((up && !sense.second_ok) [*5] |-> second_supply_fail_n_oe_q)
        else $error("second fail not shown");
    second_clear_a: assert property ((up && sense.second_ok) [*5] |-> !second_supply_fail_n_oe_q)
        else $error("second fail not released");
    main_low_a: assert property ((up && !sense.main_ok) [*5] |-> !early_supply_low_n_q && reset_q)
        else $error("main low not shown");
    main_high_a: assert property ((up && sense.main_ok) [*5] |-> early_supply_low_n_q)
        else $error("early low not released");
    manual_hold_a: assert property ((up && !sense.manual_reset_n) [*5] |-> reset_q)
        else $error("manual reset not held");
    delay_hold_a: assert property ((up && !sense.main_ok) [*5] ##1 sense.main_ok |-> reset_q [*8])
        else $error("reset dropped without delay");
    reset_pair_a: assert property (reset_q == reset_n_oe_q)
        else $error("reset outputs disagree");
endmodule
bind srw_top srw_checker chk (.clk(clk), .nrst(nrst), .sense(sense), .write_protect(write_protect), .req(req),
    .mem_wr_en_q(mem_wr_en_q), .reset_n_oe_q(reset_n_oe_q), .reset_q(reset_q),
    .early_supply_low_n_q(early_supply_low_n_q), .second_supply_fail_n_oe_q(second_supply_fail_n_oe_q),
    .third_supply_fail_n_oe_q(third_supply_fail_n_oe_q));

//--- verif/srw_host_model.sv
// Purpose: Host side of the two-wire bus, only the shortest watchdog restart
// Assumes: Pull-ups on both lines, so a released line reads high
// Notes: Phase length is a task argument, to restart both promptly and slowly
`timescale 1ns/1ps
module srw_host_model (
    input wire logic clk,
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic restart(input int hold);
        repeat (hold) @(posedge clk);
        sda <= 1'b0;
        repeat (hold) @(posedge clk);
        scl <= 1'b0;
        repeat (hold) @(posedge clk);
        scl <= 1'b1;
        repeat (hold) @(posedge clk);
        sda <= 1'b1;
    endtask
endmodule

//--- verif/testbench.sv
// Purpose: Self-checking bench for srw_top
// Assumes: Delays and periods are millions of cycles, so reset stays active all run
// Notes: Read results go through a queue to a monitor
`timescale 1ns/1ps
module testbench
    import srw_pkg::*;
;
    logic clk, nrst, write_protect, scl, sda, mem_wr_en_q, reset_n_oe_q, reset_q, early_supply_low_n_q;
    logic rd_d = 1'b0;
    logic second_supply_fail_n_oe_q, third_supply_fail_n_oe_q, watchdog_alarm_n_oe_q, irq_q;
    logic [7:0] rdata_q;
    srw_sense_t sense;
    srw_req_t req;
    logic [7:0] exp_q[$];
    int n_errors = 0;
    int checks_done = 0;
    int seed = 92619;
    int cycles = 0;
    srw_top dut (.clk(clk), .nrst(nrst), .sense(sense), .write_protect(write_protect), .scl_in(scl), .sda_in(sda),
        .req(req), .rdata_q(rdata_q), .mem_wr_en_q(mem_wr_en_q), .reset_n_oe_q(reset_n_oe_q), .reset_q(reset_q),
        .early_supply_low_n_q(early_supply_low_n_q), .second_supply_fail_n_oe_q(second_supply_fail_n_oe_q),
        .third_supply_fail_n_oe_q(third_supply_fail_n_oe_q), .watchdog_alarm_n_oe_q(watchdog_alarm_n_oe_q),
        .irq_q(irq_q));
    srw_host_model host (.clk(clk), .scl(scl), .sda(sda));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
        checks_done++;
        if (seen !== expv) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, expv, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(posedge clk);
        req.rd <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so look exactly there
    always @(posedge clk) begin
        if (rd_d) check("rdata", rdata_q, exp_q.pop_front());
        rd_d <= req.rd;
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        logic [7:0] v;
        srw_sense_t s;
        nrst = 1'b0;
        sense = 4'hF;
        write_protect = 1'b0;
        req = '0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        rd(SRW_ADDR_CTRL, 8'h61);
        rd(4'hF, 8'h00);
        rd(SRW_ADDR_IRQ_MASK, 8'h00);
        write_protect <= 1'b1;
        wr(SRW_ADDR_CTRL, 8'h00);
        @(posedge clk);
        check("mem_wr", mem_wr_en_q, 1'b0);
        write_protect <= 1'b0;
        rd(SRW_ADDR_CTRL, 8'h61);
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed)) & 8'hE1;
            wr(SRW_ADDR_CTRL, v);
            @(posedge clk);
            check("mem_wr", mem_wr_en_q, 1'b1);
            rd(SRW_ADDR_CTRL, v);
        end
        for (int i = 0; i < 10; i++) begin
            s = 4'($random(seed));
            sense <= s;
            repeat (6) @(posedge clk);
            check("early", early_supply_low_n_q, s.main_ok);
            check("second", second_supply_fail_n_oe_q, !s.second_ok);
            check("third", third_supply_fail_n_oe_q, !s.third_ok);
            check("reset", reset_q, 1'b1);
            check("reset_od", reset_n_oe_q, 1'b1);
        end
        sense <= 4'hF;
        repeat (6) @(posedge clk);
        wr(SRW_ADDR_IRQ_STAT, 8'h1F);
        rd(SRW_ADDR_IRQ_STAT, 8'h00);
        sense.second_ok <= 1'b0;
        repeat (6) @(posedge clk);
        rd(SRW_ADDR_IRQ_STAT, 8'h01 << SRW_EV_V2);
        rd(SRW_ADDR_STAT, (8'h01 << SRW_EV_V2) | (8'h01 << SRW_EV_RESET));
        @(posedge clk);
        check("irq", irq_q, 1'b0);
        wr(SRW_ADDR_IRQ_MASK, 8'h01 << SRW_EV_V2);
        repeat (2) @(posedge clk);
        check("irq", irq_q, 1'b1);
        write_protect <= 1'b1;
        wr(SRW_ADDR_IRQ_STAT, 8'hFF);
        repeat (2) @(posedge clk);
        check("irq", irq_q, 1'b1);
        write_protect <= 1'b0;
        wr(SRW_ADDR_IRQ_STAT, 8'hFF);
        repeat (2) @(posedge clk);
        check("irq", irq_q, 1'b0);
        // Shortest period is still millions of cycles, so only restart traffic is exercised here
        wr(SRW_ADDR_CTRL, 8'h41);
        host.restart(4);
        host.restart(1);
        repeat (8) @(posedge clk);
        check("alarm", watchdog_alarm_n_oe_q, 1'b0);
        tally_and_finish();
    end
endmodule
